// ---- pkg/pbdt_map.svh ----
// Purpose: Timing and layout constants for the programmable binary delay timer
// Assumes: 20 MHz reference clock
// Notes:   Base period is given in ns and converted to cycles
`ifndef PBDT_MAP_SVH
`define PBDT_MAP_SVH
`define PBDT_CLK_PERIOD_NS   50
`define PBDT_BASE_PERIOD_NS  1000
`define PBDT_BASE_CYCLES     (`PBDT_BASE_PERIOD_NS / `PBDT_CLK_PERIOD_NS)
`define PBDT_PULSE_NS        500
`define PBDT_PULSE_CYCLES    ((`PBDT_PULSE_NS + `PBDT_CLK_PERIOD_NS - 1) / `PBDT_CLK_PERIOD_NS)
`define PBDT_COUNT_W         8
`define PBDT_COUNT_START     8'h00
`define PBDT_COUNT_CLEARED   8'hff
`define PBDT_SYNC_M_MAX      10
`endif

// ---- pkg/pbdt_pkg.sv ----
// Purpose: Types for the programmable binary delay timer
// Assumes: Constants live in pbdt_map.svh
// Notes:   One-hot control states
package pbdt_pkg;
  typedef enum logic [1:0] {
    PBDT_CLEARED = 2'b01,
    PBDT_RUNNING = 2'b10
  } pbdt_state_t;

  typedef struct packed {
    logic start;
    logic clear;
  } pbdt_ctrl_t;
endpackage : pbdt_pkg

// ---- src/pbdt_sync3.sv ----
// Purpose: Three-flop input synchroniser with agreement filter
// Assumes: Input is asynchronous to clk_in
// Notes:   Output changes only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pbdt_sync3
  import pbdt_pkg::*;
#(
  parameter int WIDTH = 1
)(
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] idle_in,
  output logic      [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] lvl_q;

  initial
  begin
    if (WIDTH < 1) $error("pbdt_sync3: WIDTH must be at least 1");
  end

  // Idle value is a constant at each instance so reset stays constant-only
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      lvl_q <= '0;
    end
    else
    begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < WIDTH; i++)
      begin
        if (s2_q[i] == s3_q[i]) lvl_q[i] <= s3_q[i];
      end
    end
  end

  assign level_out = lvl_q ^ idle_in ^ idle_in;
endmodule : pbdt_sync3
`default_nettype wire

// ---- src/pbdt_timer.sv ----
// Purpose: Programmable binary delay timer: time base, 8-bit counter, control flop
// Assumes: Start, clear and sync pins are asynchronous and active high pulses
// Notes:   Open-collector taps: oe high pulls the tap low; released tap reads high
`timescale 1ns/1ps
`default_nettype none
`include "pbdt_map.svh"

module pbdt_timer
  import pbdt_pkg::*;
#(
  parameter int BASE_CYCLES  = `PBDT_BASE_CYCLES,
  parameter int PULSE_CYCLES = `PBDT_PULSE_CYCLES
)(
  input  wire logic       ref_clk_in,
  input  wire logic       arst_n_in,
  input  wire logic       start_pulse_input_in,
  input  wire logic       clear_in,
  input  wire logic       sync_modulation_input_in,
  input  wire logic       timebase_pulse_node_in,
  input  wire logic       timebase_enable_in,
  input  wire logic [7:0] tap_join_in,
  input  wire logic       bus_feedback_in,
  input  wire logic       auto_start_in,
  output logic            timebase_pulse_node_oe_out,
  output logic            timebase_pulse_node_out,
  output logic [7:0]      tap_oe_out,
  output logic [7:0]      tap_out,
  output logic            bus_low_out,
  output logic            running_out
);
  localparam int CNT_W = (BASE_CYCLES > 1) ? $clog2(BASE_CYCLES) : 1;

  initial
  begin
    if (BASE_CYCLES < 2) $error("pbdt_timer: BASE_CYCLES must be at least 2");
    // The pin filter needs two equal samples, so each node level must last two clocks
    if (PULSE_CYCLES < 2 || PULSE_CYCLES > BASE_CYCLES - 2) $error("pbdt_timer: PULSE_CYCLES out of range");
  end

  logic [1:0]        rst_sync_q;
  logic              rst_n;
  pbdt_ctrl_t        ctrl;
  logic              sync_lvl;
  logic              tbo_lvl;
  logic [2:0]        pin_lvl;
  pbdt_state_t       state_q;
  pbdt_state_t       state_d;
  logic [CNT_W-1:0]  phase_q;
  logic [7:0]        count_q;
  logic              tbo_prev_q;
  logic              sync_prev_q;
  logic              auto_done_q;
  logic              start_prev_q;
  logic              clear_prev_q;

  // Reset release through two flops
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in) rst_sync_q <= 2'b00;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // Pins cross into the clock domain; node idles high through its pull-up
  pbdt_sync3 #(.WIDTH(3)) u_sync (
    .clk_in    (ref_clk_in),
    .rst_n_in  (rst_n),
    .async_in  ({~timebase_pulse_node_in, sync_modulation_input_in, start_pulse_input_in}),
    .idle_in   (3'b000),
    .level_out (pin_lvl)
  );
  assign tbo_lvl  = ~pin_lvl[2];
  assign sync_lvl = pin_lvl[1];

  logic clear_lvl;
  pbdt_sync3 #(.WIDTH(1)) u_sync_clr (
    .clk_in    (ref_clk_in),
    .rst_n_in  (rst_n),
    .async_in  (clear_in),
    .idle_in   (1'b0),
    .level_out (clear_lvl)
  );

  // Positive-going edges act as the control pulses
  wire start_edge = pin_lvl[0] & ~start_prev_q;
  wire clear_edge = clear_lvl & ~clear_prev_q;
  assign ctrl.start = start_edge | (auto_start_in & ~auto_done_q);
  // Feedback bus is on this clock, so it clears with no filter delay
  assign ctrl.clear = clear_edge | (bus_feedback_in & ~bus_low_out & (state_q == PBDT_RUNNING));

  // Start only acts from the cleared state; start beats clear
  wire take_start = ctrl.start & (state_q == PBDT_CLEARED);
  wire take_clear = ctrl.clear & ~ctrl.start & (state_q == PBDT_RUNNING);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      PBDT_CLEARED: if (take_start) state_d = PBDT_RUNNING;
      PBDT_RUNNING: if (take_clear) state_d = PBDT_CLEARED;
      default:      state_d = PBDT_CLEARED;
    endcase
  end

  // Sync rising edge realigns the phase; the source keeps its period at m base periods
  wire sync_edge = sync_lvl & ~sync_prev_q;
  wire phase_end = (phase_q == CNT_W'(BASE_CYCLES - 1));
  wire phase_wrap = phase_end | sync_edge;
  wire [CNT_W-1:0] phase_inc = phase_q + CNT_W'(1);
  wire is_running = (state_q == PBDT_RUNNING);
  wire pulse_low = timebase_enable_in & is_running
                   & (phase_q >= CNT_W'(BASE_CYCLES - PULSE_CYCLES));

  // Counting uses the node as seen on the wire, so an outside clock or clamp rules
  wire tbo_fall = tbo_prev_q & ~tbo_lvl;
  wire [7:0] count_inc = count_q + 8'h01;
  wire hold_cleared = ~is_running | take_clear;

  // Edge history; the node history idles high so reset release shows no false fall
  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tbo_prev_q   <= 1'b1;
      sync_prev_q  <= 1'b0;
      start_prev_q <= 1'b0;
      clear_prev_q <= 1'b0;
    end
    else
    begin
      tbo_prev_q   <= tbo_lvl;
      sync_prev_q  <= sync_lvl;
      start_prev_q <= pin_lvl[0];
      clear_prev_q <= clear_lvl;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n) state_q <= PBDT_CLEARED;
    else state_q <= state_d;
  end

  // Phase stands still outside a cycle, which is what halts the base on clear
  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n) phase_q <= '0;
    else if (take_start || hold_cleared) phase_q <= '0;
    else if (phase_wrap) phase_q <= '0;
    else phase_q <= phase_inc;
  end

  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n) count_q <= `PBDT_COUNT_CLEARED;
    else if (take_start) count_q <= `PBDT_COUNT_START;
    else if (hold_cleared) count_q <= `PBDT_COUNT_CLEARED;
    else if (tbo_fall) count_q <= count_inc;
  end

  // Continuous mode: the strap fires one start after reset release and never again
  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n) auto_done_q <= 1'b0;
    else auto_done_q <= 1'b1;
  end

  // Taps pull low when their count bit is zero; wired-OR bus is low if any joined tap is
  assign tap_oe_out  = ~count_q;
  assign tap_out     = 8'h00;
  assign bus_low_out = |(tap_join_in & ~count_q);
  assign timebase_pulse_node_oe_out = pulse_low;
  assign timebase_pulse_node_out    = 1'b0;
  assign running_out = is_running;

  // Checks run on the synchronised reset, in the one clock domain
  sequence seq_start_taken;
    take_start;
  endsequence

  sequence seq_cycle_open;
    running_out && (tap_oe_out == 8'hff);
  endsequence

  sequence seq_taps_released;
    (tap_oe_out == 8'h00) && !bus_low_out && !running_out;
  endsequence

  AST_CLEARED_TAPS_HIGH: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    (state_q == PBDT_CLEARED) |-> (tap_oe_out == 8'h00))
    else $error("Taps not released while cleared");

  AST_START_TAPS_LOW: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    take_start |=> (tap_oe_out == 8'hff) && running_out)
    else $error("Start did not drive taps low");

  AST_START_IGNORED: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    (running_out && ctrl.start && !take_clear) |=> $stable(running_out))
    else $error("Start disturbed cycle");

  AST_CLEAR_HALTS_BASE: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    take_clear |=> !timebase_pulse_node_oe_out[*2])
    else $error("Base kept running after clear");

  AST_START_WINS: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    (ctrl.start && ctrl.clear && !running_out) |=> running_out)
    else $error("Clear beat start");

  AST_NO_COUNT_HELD_LOW: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    (running_out && !tbo_lvl && !tbo_prev_q && !take_clear) |=> $stable(count_q))
    else $error("Counted while held low");

  AST_COUNT_ON_FALL: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    (running_out && tbo_fall && !take_clear && !take_start) |=> count_q == $past(count_q) + 8'h01)
    else $error("Missed falling edge");

  AST_BUS_WIRED_OR: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    (|(tap_join_in & tap_oe_out)) |-> bus_low_out)
    else $error("Bus high with a tap low");

  AST_PULSE_WIDTH: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    $rose(timebase_pulse_node_oe_out) && timebase_enable_in && running_out && !take_clear
      |-> ##[1:PULSE_CYCLES] !timebase_pulse_node_oe_out)
    else $error("Base pulse too long");

  AST_START_OPENS: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    seq_start_taken |=> seq_cycle_open)
    else $error("Start did not open a cycle");

  AST_ONE_SHOT_LOW: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    (take_start && (tap_join_in != 8'h00)) |=> bus_low_out)
    else $error("Bus not low after start");

  AST_FB_CLEAR: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    (bus_feedback_in && running_out && !bus_low_out && !ctrl.start) |=> !running_out)
    else $error("One-shot did not clear itself");

  AST_CLEAR_PIN: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    (clear_edge && !ctrl.start && running_out) |=> seq_taps_released)
    else $error("Clear pulse did not end the cycle");

  AST_CLEAR_DONE_TAPS: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    take_clear |=> seq_taps_released)
    else $error("Taps held after clear");

  AST_FREE_RUN: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    (!bus_feedback_in && running_out && !clear_edge) |=> running_out)
    else $error("Free run ended by itself");

  AST_AUTO_START: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    (auto_start_in && !auto_done_q && !running_out) |=> running_out)
    else $error("No self start after reset");

  AST_AUTO_ONCE: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    (auto_done_q && !start_edge && !running_out) |=> !running_out)
    else $error("Self start repeated");

  AST_CLEARED_STAYS: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    (!running_out && !ctrl.start) |=> !running_out)
    else $error("Left cleared state without start");

  AST_RESTART_BLOCKED: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    (running_out && start_edge) |=> running_out)
    else $error("Start while running ended cycle");

  AST_BASE_IDLE_HIGH: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    !running_out |-> !timebase_pulse_node_oe_out)
    else $error("Base pulse while cleared");

  AST_DISABLED_BASE: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    !timebase_enable_in |-> !timebase_pulse_node_oe_out)
    else $error("Disabled base drove node");

  AST_COUNT_FREEZE: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    (running_out && !tbo_fall && !take_clear) |=> $stable(count_q))
    else $error("Count moved without a fall");

  AST_BUS_HIGH_NO_TAP: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    !(|(tap_join_in & tap_oe_out)) |-> !bus_low_out)
    else $error("Bus low with no tap low");

  AST_SYNC_REALIGN: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    (running_out && sync_edge && !take_clear) |=> (phase_q == '0))
    else $error("Sync did not realign phase");

  AST_PHASE_HOLD: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    !running_out |-> (phase_q == '0))
    else $error("Base phase ran while cleared");
endmodule : pbdt_timer
`default_nettype wire

// ---- verification/pbdt_pulse_src.sv ----
// Purpose: Far-side model: start, clear and sync sources, external clock on the pulse node
// Assumes: The pulse node has a pull-up; either party may pull it low
// Notes:   Drives 1 ns after a rising edge so the design never races it
`timescale 1ns/1ps
`default_nettype none
module pbdt_pulse_src #(
  parameter int BASE = 4
)(
  input  wire logic clk_in,
  input  wire logic node_oe_in,
  output logic      start_out,
  output logic      clear_out,
  output logic      sync_out,
  output logic      node_out
);
  logic pull_q;
  initial
  begin
    {start_out, clear_out, sync_out, pull_q} = 4'h0;
  end
  assign node_out = ~(node_oe_in | pull_q);
  // Sel 0 start, 1 clear, 2 both at once
  task automatic pulse(input int sel, input int cyc);
    @(posedge clk_in) #1;
    start_out = (sel != 1);
    clear_out = (sel != 0);
    repeat (cyc) @(posedge clk_in);
    #1 {start_out, clear_out} = 2'h0;
  endtask : pulse
  // Low phases shorter than two clocks could be lost in the input filter
  task automatic ext_clk(input int falls, input int low);
    repeat (falls)
    begin
      @(posedge clk_in) #1 pull_q = 1'b1;
      repeat (low) @(posedge clk_in);
      #1 pull_q = 1'b0;
      repeat (3) @(posedge clk_in);
    end
  endtask : ext_clk
  task automatic sync_train(input int m, input int k);
    repeat (k)
    begin
      // Two clocks high so the input filter keeps the pulse
      @(posedge clk_in) #1 sync_out = 1'b1;
      repeat (2) @(posedge clk_in);
      #1 sync_out = 1'b0;
      repeat (m * BASE - 3) @(posedge clk_in);
    end
  endtask : sync_train
endmodule : pbdt_pulse_src
`default_nettype wire

// ---- verification/programmable_binary_delay_timer_tb_top.sv ----
// Purpose: Self-checking bench for the programmable binary delay timer
// Assumes: Short base period of 4 clocks and a 2-clock node pulse
// Notes:   One-shot widths carry one base period of slack for start phase
`timescale 1ns/1ps
`default_nettype none
module programmable_binary_delay_timer_tb_top;
  localparam int B = 4;
  logic       ref_clk_in = 1'b0;
  logic       arst_n     = 1'b0;
  logic       tb_en      = 1'b1;
  logic       fb         = 1'b0;
  logic       auto_q     = 1'b0;
  logic [7:0] join_q     = 8'h00;
  logic       start, clear, sync, node, node_oe, bus_low, running;
  logic [7:0] tap_oe;
  int         n_mismatch = 0;
  int         n_tests    = 0;
  int         cycles     = 0;
  always #25 ref_clk_in = ~ref_clk_in;
  pbdt_timer #(.BASE_CYCLES(B), .PULSE_CYCLES(2)) u_pbdt_timer (
    .ref_clk_in(ref_clk_in), .arst_n_in(arst_n), .start_pulse_input_in(start), .clear_in(clear),
    .sync_modulation_input_in(sync), .timebase_pulse_node_in(node), .timebase_enable_in(tb_en),
    .tap_join_in(join_q), .bus_feedback_in(fb), .auto_start_in(auto_q),
    .timebase_pulse_node_oe_out(node_oe), .timebase_pulse_node_out(), .tap_oe_out(tap_oe),
    .tap_out(), .bus_low_out(bus_low), .running_out(running));
  pbdt_pulse_src #(.BASE(B)) u_pbdt_pulse_src (
    .clk_in(ref_clk_in), .node_oe_in(node_oe), .start_out(start), .clear_out(clear),
    .sync_out(sync), .node_out(node));
  task automatic final_report();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h", $time, msg, got);
    end
  endtask : chk
  task automatic chk_rng(input int got, input int lo, input int hi, input string msg);
    n_tests++;
    if (got < lo || got > hi)
    begin
      n_mismatch++;
      $display("unexpected at %0t: %s width %0d", $time, msg, got);
    end
  endtask : chk_rng
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask : tick
  function automatic logic pick(input int sel);
    return (sel == 0) ? tap_oe[0] : bus_low;
  endfunction : pick
  // Width of the next full phase at level lvl
  task automatic meas(input int sel, input logic lvl, output int n);
    n = 0;
    while (pick(sel) === lvl) tick(1);
    while (pick(sel) !== lvl) tick(1);
    while (pick(sel) === lvl && n < 3000)
    begin
      n++;
      tick(1);
    end
  endtask : meas
  task automatic sc_oneshot(input logic [7:0] n, input bit retrig);
    int w;
    join_q = n;
    fb = 1'b1;
    if (retrig)
      fork
        begin
          tick(n * B / 2);
          u_pbdt_pulse_src.pulse(0, 3);
        end
      join_none
    u_pbdt_pulse_src.pulse(0, 3);
    meas(1, 1'b1, w);
    chk_rng(w, n * B - B, n * B + B, "one-shot length");
    tick(10);
    chk({running, bus_low, 6'h00}, 8'h00, "after self clear");
    chk(tap_oe, 8'h00, "taps after self clear");
  endtask : sc_oneshot
  task automatic sc_freerun();
    int w;
    logic seen;
    join_q = 8'h03;
    fb = 1'b0;
    u_pbdt_pulse_src.pulse(0, 3);
    fork
      u_pbdt_pulse_src.sync_train(10, 6);
    join_none
    tick(80);
    meas(0, 1'b1, w);
    chk_rng(w, B, B, "tap high phase");
    meas(0, 1'b0, w);
    chk_rng(w, B, B, "tap low phase");
    meas(1, 1'b1, w);
    chk_rng(w, 3 * B, 3 * B, "pattern low part");
    meas(1, 1'b0, w);
    chk_rng(w, B, B, "narrowest pulse");
    tick(200);
    chk({7'h00, running}, 8'h01, "free run goes on");
    u_pbdt_pulse_src.pulse(1, 3);
    tick(6);
    chk({running, 7'h00}, 8'h00, "cleared by pulse");
    seen = 1'b0;
    repeat (3 * B)
    begin
      seen = seen | node_oe;
      tick(1);
    end
    chk({7'h00, seen}, 8'h00, "base halted");
  endtask : sc_freerun
  task automatic sc_both();
    join_q = 8'h00;
    u_pbdt_pulse_src.pulse(2, 3);
    tick(6);
    chk({7'h00, running}, 8'h01, "start over clear");
    u_pbdt_pulse_src.pulse(1, 3);
    tick(6);
    chk({7'h00, running}, 8'h00, "cleared after both");
  endtask : sc_both
  task automatic sc_auto();
    auto_q = 1'b1;
    arst_n = 1'b0;
    tick(8);
    arst_n = 1'b1;
    tick(12);
    chk({7'h00, running}, 8'h01, "self start after reset");
    u_pbdt_pulse_src.pulse(1, 3);
    tick(12);
    chk({7'h00, running}, 8'h00, "no second self start");
    auto_q = 1'b0;
  endtask : sc_auto
  task automatic sc_extclk();
    tb_en = 1'b0;
    u_pbdt_pulse_src.pulse(0, 3);
    tick(6);
    chk(tap_oe, 8'hff, "count starts at zero");
    u_pbdt_pulse_src.ext_clk(5, 3);
    tick(4);
    chk(tap_oe, 8'hfa, "external falls counted");
    fork
      u_pbdt_pulse_src.ext_clk(1, 40);
    join_none
    tick(30);
    chk(tap_oe, 8'hf9, "held node");
    tick(20);
    u_pbdt_pulse_src.pulse(1, 3);
    tick(6);
    chk(tap_oe, 8'h00, "cleared taps");
    tb_en = 1'b1;
  endtask : sc_extclk
  always @(posedge ref_clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      final_report();
    end
  end
  initial
  begin
    tick(8);
    arst_n = 1'b1;
    tick(8);
    chk({running, bus_low, node_oe, 5'h00}, 8'h00, "idle outputs");
    chk(tap_oe, 8'h00, "idle taps");
    sc_oneshot(8'h01, 1'b0);
    sc_oneshot(8'h31, 1'b0);
    sc_oneshot(8'hff, 1'b0);
    sc_oneshot(8'h20, 1'b1);
    sc_freerun();
    sc_both();
    sc_extclk();
    sc_auto();
    final_report();
  end
endmodule : programmable_binary_delay_timer_tb_top
`default_nettype wire
